/* wwbcr_top.sv */
/*
 * Serially accessed configuration bank: watchdog setup, transceiver mode,
 * timer and wake-input wake sources, voltage-sense option, interrupt scope,
 * plus hardware rewrites on fail-safe entry and stop-to-normal.
 * Assumes a slow serial clock (at most about 1/8 of SYS_CLK_I) since every
 * serial input pin is oversampled, and mode events arriving as one-cycle pulses from
 * logic on the same clock.
 */
// What this block does
// - bit 6 is stop-mode disable flag a
// - bit 5 selects window or time-out watchdog
// - bit 4 starts watchdog after bus wake
// - bits 2:0 select watchdog period
// - bits 1:0 select transceiver mode
// - fail-safe entry forces transceiver mode to 01
// - internal bit 6 enables timer wake
// - stop flag b cleared on stop-to-normal
// - external bit 7 selects interrupt scope
// - external bit 5 selects voltage sensing
// - external bit 0 enables wake input
// - sensing without fail output ignores enables
// - sensing set refused while fail output active
// - sensing measures in normal, holds level status
// - fail-safe entry without sensing forces external to x0x0 0001
// - sensing keeps wake input off in fail-safe
// - reserved bits ignore writes, read zero
// - write answer shows previous register contents
`timescale 1ns/1ps
`include "wwbcr_params.svh"

module wwbcr_top
    import wwbcr_pkg::*;
(
    input wire logic SYS_CLK_I,         // 40 MHz system clock
    input wire logic NRST_I,            // async power-on reset, low
    input wire logic SPI_CS_N_I,        // serial chip select, low
    input wire logic SPI_CLK_I,         // serial clock pin
    input wire logic SPI_SDI_I,         // serial data in pin
    input wire logic SOFT_RESET_I,      // soft reset pulse
    input wire logic RESTART_I,         // restart mode entry pulse
    input wire logic FAILSAFE_ENTRY_I,  // fail-safe entry by failure pulse
    input wire logic STOP_TO_NORMAL_I,  // stop to normal transition pulse
    input wire logic NORMAL_MODE_I,     // device is in normal mode
    input wire logic FAIL_OUTPUT_PIN_ACTIVE_I, // fail output asserted
    output logic SPI_SDO_O,             // serial data out value
    output logic SPI_SDO_OE_N_O,        // serial out enable, low drives
    output logic SPI_FAIL_SET_O,        // serial access failure pulse
    output wwbcr_cfg_t CFG_O            // decoded configuration
);

    wwbcr_state_t q;
    wwbcr_state_t d;
    logic clk_rise;
    logic clk_fall;
    logic frame_end;
    logic [6:0] wr_addr;
    logic [7:0] wr_data;
    logic sense_live;

    // ****************************************************************
    // register read decode
    // ****************************************************************

    // unmapped addresses read zero; reserved bits are never stored
    function automatic logic [7:0] reg_read(input logic [6:0] addr,
                                            input wwbcr_state_t s);
        logic [7:0] v;
        v = 8'h00;
        case (addr)
            `WWBCR_OFS_WATCHDOG_CONFIG: v = s.watchdog_config;
            `WWBCR_OFS_CAN_MODE: v = s.can_transceiver_mode;
            `WWBCR_OFS_INTERNAL_WAKE: v = s.internal_wake_config;
            `WWBCR_OFS_EXTERNAL_WAKE: v = s.external_wake_config;
            default: v = 8'h00;
        endcase
        return v;
    endfunction

    // ****************************************************************
    // next state
    // ****************************************************************

    // one pass: pins, serial shifter, writes, hardware rewrites, outputs
    always_comb begin
        d = q;
        clk_rise = 1'b0;
        clk_fall = 1'b0;
        frame_end = 1'b0;
        wr_addr = q.sin[6:0];
        wr_data = q.sin[15:8];
        sense_live = 1'b0;
        d.spi_fail = 1'b0;

        // three-stage sampling; a level counts once stages two and three agree
        d.csn_s = {q.csn_s[1:0], SPI_CS_N_I};
        d.clk_s = {q.clk_s[1:0], SPI_CLK_I};
        d.sdi_s = {q.sdi_s[1:0], SPI_SDI_I};
        if (q.csn_s[1] == q.csn_s[2]) begin
            d.csn_f = q.csn_s[2];
        end
        if (q.clk_s[1] == q.clk_s[2]) begin
            d.clk_f = q.clk_s[2];
        end
        if (q.sdi_s[1] == q.sdi_s[2]) begin
            d.sdi_f = q.sdi_s[2];
        end
        clk_rise = d.clk_f & ~q.clk_f;
        clk_fall = ~d.clk_f & q.clk_f;

        // shifter: sample on rising edge, lsb first, only inside a frame
        if (d.csn_f) begin
            d.cnt = 5'h00;
            frame_end = ~q.csn_f & (q.cnt == `WWBCR_FRAME_BITS);
        end else if (clk_rise && q.cnt != `WWBCR_FRAME_BITS) begin
            d.sin = {d.sdi_f, q.sin[15:1]};
            d.cnt = q.cnt + 5'h01;
        end

        // answer byte is the stored value, latched before any commit
        if (!d.csn_f && clk_fall) begin
            if (q.cnt == `WWBCR_DATA_START) begin
                d.sout = reg_read(q.sin[14:8], q);
            end else if (q.cnt > `WWBCR_DATA_START) begin
                d.sout = {1'b0, q.sout[7:1]};
            end
        end

        // commit only complete write frames at chip-select release
        if (frame_end && q.sin[7]) begin
            case (wr_addr)
                `WWBCR_OFS_WATCHDOG_CONFIG: begin
                    d.watchdog_config = wr_data & `WWBCR_WMASK_WATCHDOG_CONFIG;
                end
                `WWBCR_OFS_CAN_MODE: begin
                    d.can_transceiver_mode = wr_data & `WWBCR_WMASK_CAN_MODE;
                end
                `WWBCR_OFS_INTERNAL_WAKE: begin
                    d.internal_wake_config = wr_data &
                        `WWBCR_WMASK_INTERNAL_WAKE;
                end
                `WWBCR_OFS_EXTERNAL_WAKE: begin
                    d.external_wake_config = wr_data &
                        `WWBCR_WMASK_EXTERNAL_WAKE;
                    // sensing cannot be chosen while the fail output is on
                    if (FAIL_OUTPUT_PIN_ACTIVE_I &&
                        wr_data[`WWBCR_BIT_VSENSE_SEL]) begin
                        d.external_wake_config[`WWBCR_BIT_VSENSE_SEL] =
                            1'b0;
                        d.spi_fail = 1'b1;
                    end
                end
                default: begin
                end
            endcase
        end

        // hardware rewrites follow the host write so they win a collision
        if (STOP_TO_NORMAL_I) begin
            d.internal_wake_config[`WWBCR_BIT_STOP_DOG_OFF_B] = 1'b0;
        end
        if (FAILSAFE_ENTRY_I) begin
            // keep the device wakeable over the bus
            d.can_transceiver_mode = `WWBCR_FAILSAFE_CAN_MODE;
            if (!d.external_wake_config[`WWBCR_BIT_VSENSE_SEL]) begin
                d.external_wake_config = (d.external_wake_config &
                    `WWBCR_FAILSAFE_EXT_KEEP) | `WWBCR_FAILSAFE_EXT_SET;
            end
        end
        if (RESTART_I) begin
            d.watchdog_config = (d.watchdog_config &
                `WWBCR_RSTART_KEEP_WATCHDOG) | `WWBCR_RSTART_SET_WATCHDOG;
            d.can_transceiver_mode = d.can_transceiver_mode &
                `WWBCR_RSTART_KEEP_CAN_MODE;
            d.internal_wake_config = d.internal_wake_config &
                `WWBCR_RSTART_KEEP_INT_WAKE;
            d.external_wake_config = d.external_wake_config &
                `WWBCR_RSTART_KEEP_EXT_WAKE;
        end
        if (SOFT_RESET_I) begin
            d.watchdog_config = `WWBCR_RST_WATCHDOG_CONFIG;
            d.can_transceiver_mode = `WWBCR_RST_CAN_MODE;
            d.internal_wake_config = `WWBCR_RST_INTERNAL_WAKE;
            d.external_wake_config = `WWBCR_RST_EXTERNAL_WAKE;
        end

        // serial output: zeros during the address byte, pin released when idle
        d.sdo_oe_n = d.csn_f;
        d.sdo = (!d.csn_f && d.cnt >= `WWBCR_DATA_START) ? d.sout[0] : 1'b0;

        // decoded configuration, registered so outputs come from flops
        sense_live = d.external_wake_config[`WWBCR_BIT_VSENSE_SEL] &
            ~FAIL_OUTPUT_PIN_ACTIVE_I;
        d.cfg.stop_dog_off =
            d.watchdog_config[`WWBCR_BIT_STOP_DOG_OFF_A] &
            d.internal_wake_config[`WWBCR_BIT_STOP_DOG_OFF_B];
        d.cfg.window_type_select =
            d.watchdog_config[`WWBCR_BIT_WINDOW_TYPE];
        d.cfg.dog_start_on_bus_wake =
            d.watchdog_config[`WWBCR_BIT_DOG_BUS_WAKE];
        d.cfg.dog_period_sel = d.watchdog_config[2:0];
        // parity is the host's duty; flag it rather than refuse it
        d.cfg.dog_csum_err = ^d.watchdog_config;
        d.cfg.can_mode = d.can_transceiver_mode[1:0];
        d.cfg.cyclic_wake_enable =
            d.internal_wake_config[`WWBCR_BIT_CYCLIC_WAKE];
        d.cfg.int_scope_all =
            d.external_wake_config[`WWBCR_BIT_INT_SCOPE];
        // sensing mode stops the wake input being a wake source; timer wake is unaffected
        d.cfg.wake_src_enable =
            d.external_wake_config[`WWBCR_BIT_WAKE_IN_EN] &
            ~d.external_wake_config[`WWBCR_BIT_VSENSE_SEL];
        d.cfg.vsense_meas_en = sense_live & NORMAL_MODE_I;
        d.cfg.level_status_hold = sense_live;
        d.cfg.gpio_ctrl_ignore = sense_live;
    end

    // ****************************************************************
    // state register
    // ****************************************************************

    // reset loads documented power-on values; chip select idles high
    always_ff @(posedge SYS_CLK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            q <= '0;
            q.csn_s <= 3'h7;
            q.csn_f <= 1'b1;
            q.sdo_oe_n <= 1'b1;
            q.watchdog_config <= `WWBCR_RST_WATCHDOG_CONFIG;
            q.can_transceiver_mode <= `WWBCR_RST_CAN_MODE;
            q.internal_wake_config <= `WWBCR_RST_INTERNAL_WAKE;
            q.external_wake_config <= `WWBCR_RST_EXTERNAL_WAKE;
            q.cfg.dog_start_on_bus_wake <= 1'b1;
            q.cfg.dog_period_sel <= 3'h4;
            q.cfg.wake_src_enable <= 1'b1;
        end else begin
            q <= d;
        end
    end

    // ****************************************************************
    // outputs
    // ****************************************************************

    assign SPI_SDO_O = q.sdo;
    assign SPI_SDO_OE_N_O = q.sdo_oe_n;
    assign SPI_FAIL_SET_O = q.spi_fail;
    assign CFG_O = q.cfg;

endmodule

/* wwbcr_params.svh */
/*
 * Register offsets, field positions, reset values and write masks of the
 * watchdog, transceiver-mode and wake-source configuration bank.
 * Assumes it is included by bare name from the design.
 */
`ifndef WWBCR_PARAMS_SVH
`define WWBCR_PARAMS_SVH

// ****************************************************************
// register offsets (7-bit serial address)
// ****************************************************************
`define WWBCR_OFS_WATCHDOG_CONFIG 7'h03
`define WWBCR_OFS_CAN_MODE 7'h04
`define WWBCR_OFS_INTERNAL_WAKE 7'h06
`define WWBCR_OFS_EXTERNAL_WAKE 7'h07

// ****************************************************************
// reset values (power-on and soft reset)
// ****************************************************************
`define WWBCR_RST_WATCHDOG_CONFIG 8'h14
`define WWBCR_RST_CAN_MODE 8'h00
`define WWBCR_RST_INTERNAL_WAKE 8'h00
`define WWBCR_RST_EXTERNAL_WAKE 8'h01

// ****************************************************************
// writable bits; reserved bits are zero here
// ****************************************************************
`define WWBCR_WMASK_WATCHDOG_CONFIG 8'hf7
`define WWBCR_WMASK_CAN_MODE 8'h03
`define WWBCR_WMASK_INTERNAL_WAKE 8'h44
`define WWBCR_WMASK_EXTERNAL_WAKE 8'ha1

// ****************************************************************
// restart: bits kept, the fixed part, fail-safe rewrite values
// ****************************************************************
`define WWBCR_RSTART_KEEP_WATCHDOG 8'hb0
`define WWBCR_RSTART_SET_WATCHDOG 8'h04
`define WWBCR_RSTART_KEEP_CAN_MODE 8'h03
`define WWBCR_RSTART_KEEP_INT_WAKE 8'h40
`define WWBCR_RSTART_KEEP_EXT_WAKE 8'ha1
`define WWBCR_FAILSAFE_CAN_MODE 8'h01
`define WWBCR_FAILSAFE_EXT_KEEP 8'ha0
`define WWBCR_FAILSAFE_EXT_SET 8'h01

// ****************************************************************
// field positions
// ****************************************************************
`define WWBCR_BIT_CHECKSUM 7
`define WWBCR_BIT_STOP_DOG_OFF_A 6
`define WWBCR_BIT_WINDOW_TYPE 5
`define WWBCR_BIT_DOG_BUS_WAKE 4
`define WWBCR_BIT_CYCLIC_WAKE 6
`define WWBCR_BIT_STOP_DOG_OFF_B 2
`define WWBCR_BIT_INT_SCOPE 7
`define WWBCR_BIT_VSENSE_SEL 5
`define WWBCR_BIT_WAKE_IN_EN 0

// ****************************************************************
// serial frame: 7 address bits, 1 write bit, 8 data bits, lsb first
// ****************************************************************
`define WWBCR_FRAME_BITS 5'h10
`define WWBCR_DATA_START 5'h08

`endif

/* wwbcr_pkg.sv */
/*
 * Types of the configuration bank: the decoded configuration bundle and
 * the whole module state. Assumes wwbcr_params.svh sits beside it.
 */
package wwbcr_pkg;

    // decoded configuration handed to the watchdog, transceiver and wake logic
    typedef struct packed {
        logic stop_dog_off;          // both stop-mode disable flags set
        logic window_type_select;    // 1 window, 0 time-out
        logic dog_start_on_bus_wake; // start with long open window
        logic [2:0] dog_period_sel;  // 10ms .. 10000ms code
        logic dog_csum_err;          // config byte has odd parity
        logic [1:0] can_mode;        // 00 off, 01 wake capable, 10 rx only
        logic cyclic_wake_enable;    // timer is a wake source
        logic int_scope_all;         // every status bit raises interrupt
        logic wake_src_enable;       // hv wake input is a live wake source
        logic vsense_meas_en;        // voltage measurement running
        logic level_status_hold;     // hold level status bits in reset
        logic gpio_ctrl_ignore;      // general pin settings ignored
    } wwbcr_cfg_t;

    // every flip-flop of the bank
    typedef struct packed {
        logic [2:0] csn_s;
        logic [2:0] clk_s;
        logic [2:0] sdi_s;
        logic csn_f;
        logic clk_f;
        logic sdi_f;
        logic [15:0] sin;
        logic [4:0] cnt;
        logic [7:0] sout;
        logic [7:0] watchdog_config;
        logic [7:0] can_transceiver_mode;
        logic [7:0] internal_wake_config;
        logic [7:0] external_wake_config;
        logic sdo;
        logic sdo_oe_n;
        logic spi_fail;
        wwbcr_cfg_t cfg;
    } wwbcr_state_t;

endpackage

/* wwbcr_top_asserts.sv */
/* port checker of the configuration bank.
   assumes it is bound onto wwbcr_top and that mode event pulses come
   from logic on the same clock. */
`timescale 1ns/1ps
module wwbcr_top_asserts
    import wwbcr_pkg::*;
(
    input wire logic SYS_CLK_I, // system clock
    input wire logic NRST_I, // async reset, low
    input wire logic SPI_CS_N_I, // chip select, low
    input wire logic SOFT_RESET_I, // soft reset pulse
    input wire logic RESTART_I, // restart pulse
    input wire logic FAILSAFE_ENTRY_I, // fail-safe entry pulse
    input wire logic STOP_TO_NORMAL_I, // stop to normal pulse
    input wire logic NORMAL_MODE_I, // normal mode level
    input wire logic FAIL_OUTPUT_PIN_ACTIVE_I, // fail output level
    input wire logic SPI_SDO_OE_N_O, // serial out enable, low
    input wire logic SPI_FAIL_SET_O, // refused write pulse
    input wire wwbcr_cfg_t CFG_O // decoded configuration
);
// ****************************************************************
// properties
// ****************************************************************
default clocking @(posedge SYS_CLK_I); endclocking
default disable iff (!NRST_I);
// restart and soft reset win over the lower events, so they mask them
logic hi_ev;
assign hi_ev = RESTART_I | SOFT_RESET_I;
a_failsafe_can_mode: assert property (FAILSAFE_ENTRY_I && !hi_ev
    |=> CFG_O.can_mode == 2'h1) else $error("can mode not forced");
a_failsafe_wake_on: assert property (FAILSAFE_ENTRY_I && !hi_ev &&
    !CFG_O.level_status_hold && !FAIL_OUTPUT_PIN_ACTIVE_I
    |=> CFG_O.wake_src_enable) else $error("wake input not forced");
a_sense_no_wake: assert property (FAILSAFE_ENTRY_I && !hi_ev &&
    CFG_O.gpio_ctrl_ignore |=> !CFG_O.wake_src_enable)
    else $error("wake source on while sensing");
a_stop_flag_clear: assert property (STOP_TO_NORMAL_I && !hi_ev
    |=> !CFG_O.stop_dog_off) else $error("stop flag kept");
a_ignore_no_wake: assert property (CFG_O.gpio_ctrl_ignore
    |-> !CFG_O.wake_src_enable) else $error("wake enable not ignored");
a_meas_normal_only: assert property (!NORMAL_MODE_I
    |=> !CFG_O.vsense_meas_en) else $error("measuring outside normal");
a_fo_lifts_ignore: assert property (FAIL_OUTPUT_PIN_ACTIVE_I
    |=> !CFG_O.gpio_ctrl_ignore && !CFG_O.level_status_hold)
    else $error("ignore held with fail output");
a_fail_pulse_once: assert property (SPI_FAIL_SET_O
    |=> !SPI_FAIL_SET_O) else $error("fail pulse too long");
a_fail_after_cs: assert property (SPI_FAIL_SET_O
    |-> $past(SPI_CS_N_I, 2) && FAIL_OUTPUT_PIN_ACTIVE_I)
    else $error("fail pulse without cause");
a_soft_defaults: assert property (SOFT_RESET_I |=>
    CFG_O.dog_period_sel == 3'h4 && CFG_O.can_mode == 2'h0)
    else $error("soft reset values wrong");
a_oe_follows_cs: assert property ($rose(SPI_CS_N_I)
    |-> ##[1:8] SPI_SDO_OE_N_O) else $error("serial out kept driven");
c_fail_set: cover property (SPI_FAIL_SET_O);
c_failsafe: cover property (FAILSAFE_ENTRY_I);
c_measuring: cover property (CFG_O.vsense_meas_en);
endmodule

bind wwbcr_top wwbcr_top_asserts u_chk (
    .SYS_CLK_I, .NRST_I, .SPI_CS_N_I, .SOFT_RESET_I, .RESTART_I,
    .FAILSAFE_ENTRY_I, .STOP_TO_NORMAL_I, .NORMAL_MODE_I,
    .FAIL_OUTPUT_PIN_ACTIVE_I, .SPI_SDO_OE_N_O, .SPI_FAIL_SET_O, .CFG_O
);

/* wwbcr_host_model.sv */
/* host side of the serial link: sends 16-bit frames lsb first and
   collects the answer byte. assumes the device oversamples its pins. */
`timescale 1ns/1ps
module wwbcr_host_model (
    input wire logic clk_i, // system clock for pacing
    input wire logic sdo_i, // device serial out
    output logic cs_n_o, // chip select, low
    output logic sck_o, // serial clock, idle low
    output logic sdi_o // serial data in
);
// ****************************************************************
// frame driver
// ****************************************************************
// ten cycles a phase leaves margin over the 3-flop filter
localparam int HALF = 10;
initial begin
    cs_n_o = 1'b1;
    sck_o = 1'b0;
    sdi_o = 1'b0;
end
// each answer bit is taken just before the rise that follows its fall
task automatic xfer(input logic [6:0] a, input logic w,
    input logic [7:0] d, output logic [7:0] q);
    logic [15:0] fr;
    fr = {d, w, a};
    cs_n_o <= 1'b0;
    for (int i = 0; i < 16; i++) begin
        sck_o <= 1'b0;
        sdi_o <= fr[i];
        repeat (HALF) @(posedge clk_i);
        if (i >= 8) q[i-8] = sdo_i;
        sck_o <= 1'b1;
        repeat (HALF) @(posedge clk_i);
    end
    sck_o <= 1'b0;
    repeat (HALF) @(posedge clk_i);
    cs_n_o <= 1'b1;
    sdi_o <= ~sdi_o; // released line does not keep its last value
    repeat (HALF) @(posedge clk_i);
endtask
endmodule

/* wwbcr_tb_top.sv */
/* self-checking bench of the configuration bank.
   assumes the host model beside it and the bound port checker. */
`timescale 1ns/1ps
module wwbcr_tb_top import wwbcr_pkg::*;;
logic clk, nrst, cs_n, sck, sdi, sdo, oe_n, fail_set, normal, fo;
logic [3:0] ev; // soft, restart, fail-safe, stop to normal
wwbcr_cfg_t cfg;
logic [7:0] sh [0:7]; // expected register contents
int n_fail, checks_done, n_fs, cyc;
wwbcr_top DUT (.SYS_CLK_I(clk), .NRST_I(nrst), .SPI_CS_N_I(cs_n),
    .SPI_CLK_I(sck), .SPI_SDI_I(sdi), .SOFT_RESET_I(ev[3]),
    .RESTART_I(ev[2]), .FAILSAFE_ENTRY_I(ev[1]),
    .STOP_TO_NORMAL_I(ev[0]), .NORMAL_MODE_I(normal),
    .FAIL_OUTPUT_PIN_ACTIVE_I(fo), .SPI_SDO_O(sdo),
    .SPI_SDO_OE_N_O(oe_n), .SPI_FAIL_SET_O(fail_set), .CFG_O(cfg));
wwbcr_host_model u_host (.clk_i(clk), .sdo_i(sdo), .cs_n_o(cs_n),
    .sck_o(sck), .sdi_o(sdi));
// ****************************************************************
// helpers
// ****************************************************************
initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
end
// the ceiling is about twice the expected run
always @(posedge clk) begin
    cyc++;
    if (fail_set === 1'b1) n_fs++;
    if (cyc == 40000) begin
        n_fail++;
        report_and_stop();
    end
end
task automatic report_and_stop();
    if (n_fail == 0 && checks_done > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
endtask
task automatic chk(input string s, input logic [7:0] g, e);
    checks_done++;
    if (g !== e) begin
        n_fail++;
        $display("MISMATCH %s expected %h seen %h", s, e, g);
    end
endtask
function automatic logic [7:0] msk(input logic [6:0] a);
    case (a)
        7'h03: return 8'hf7;
        7'h04: return 8'h03;
        7'h06: return 8'h44;
        7'h07: return 8'ha1;
        default: return 8'h00;
    endcase
endfunction
task automatic wr(input logic [6:0] a, input logic [7:0] d);
    logic [7:0] q;
    u_host.xfer(a, 1'b1, d, q);
    chk("write answer", q, sh[a[2:0]]);
    sh[a[2:0]] = d & msk(a);
endtask
task automatic rd(input logic [6:0] a);
    logic [7:0] q;
    u_host.xfer(a, 1'b0, 8'h00, q);
    chk("read", q, sh[a[2:0]]);
endtask
task automatic rd_all();
    for (int a = 3; a < 8; a++) rd(7'(a));
endtask
task automatic pulse(input logic [3:0] p);
    ev <= p;
    @(posedge clk);
    ev <= 4'h0;
    repeat (3) @(posedge clk);
endtask
task automatic defaults();
    sh = '{8'h00, 8'h00, 8'h00, 8'h14, 8'h00, 8'h00, 8'h00, 8'h01};
endtask
// ****************************************************************
// main sequence
// ****************************************************************
initial begin
    logic [6:0] lo;
    nrst = 1'b0;
    ev = 4'h0;
    normal = 1'b1;
    fo = 1'b0;
    defaults();
    repeat (20) @(posedge clk);
    nrst <= 1'b1;
    repeat (5) @(posedge clk);
    chk("oe idle", oe_n, 1);
    chk("sdo idle", sdo, 0);
    rd_all();
    chk("wake src", cfg.wake_src_enable, 1);
    // every period code, reserved bit 3 set and even parity kept
    for (int c = 0; c < 8; c++) begin
        lo = 7'h20 | 7'(c);
        wr(7'h03, {^lo, lo | 7'h08});
        chk("period", cfg.dog_period_sel, 8'(c));
        chk("window", cfg.window_type_select, 1);
        chk("checksum", cfg.dog_csum_err, 0);
    end
    rd(7'h03);
    wr(7'h03, 8'h50);
    chk("bus wake", cfg.dog_start_on_bus_wake, 1);
    chk("stop off", cfg.stop_dog_off, 0);
    for (int c = 0; c < 3; c++) begin
        wr(7'h04, 8'hfc | 8'(c));
        chk("can mode", cfg.can_mode, 8'(c));
    end
    rd(7'h04);
    wr(7'h04, 8'h01);
    wr(7'h06, 8'hff);
    rd(7'h06);
    chk("cyclic", cfg.cyclic_wake_enable, 1);
    chk("stop off", cfg.stop_dog_off, 1);
    pulse(4'h1);
    sh[6] = 8'h40;
    rd(7'h06);
    chk("stop off", cfg.stop_dog_off, 0);
    wr(7'h06, 8'h04);
    chk("cyclic", cfg.cyclic_wake_enable, 0);
    wr(7'h07, 8'h81);
    chk("scope", cfg.int_scope_all, 1);
    chk("wake src", cfg.wake_src_enable, 1);
    wr(7'h07, 8'hff);
    rd(7'h07);
    chk("ignore", cfg.gpio_ctrl_ignore, 1);
    chk("wake src", cfg.wake_src_enable, 0);
    chk("meas", cfg.vsense_meas_en, 1);
    normal <= 1'b0;
    repeat (3) @(posedge clk);
    chk("meas", cfg.vsense_meas_en, 0);
    chk("hold", cfg.level_status_hold, 1);
    normal <= 1'b1;
    pulse(4'h2);
    sh[4] = 8'h01;
    rd_all();
    chk("wake src", cfg.wake_src_enable, 0);
    wr(7'h04, 8'h00);
    wr(7'h07, 8'h80);
    pulse(4'h2);
    sh[4] = 8'h01;
    sh[7] = 8'h81;
    rd_all();
    chk("wake src", cfg.wake_src_enable, 1);
    // sensing refused while the fail output is up
    fo <= 1'b1;
    wr(7'h07, 8'h21);
    sh[7] = 8'h01;
    rd(7'h07);
    chk("fail pulses", 8'(n_fs), 1);
    fo <= 1'b0;
    wr(7'h05, 8'hff);
    rd(7'h05);
    pulse(4'h4);
    sh[3] = (sh[3] & 8'hb0) | 8'h04;
    sh[6] = sh[6] & 8'h40;
    rd_all();
    pulse(4'h8);
    defaults();
    rd_all();
    report_and_stop();
end
endmodule
